// File: common/dpc_pkg.sv
// Shared constants and types for the dual-port RAM port control
package dpc_pkg;
  localparam int DPC_AW = 18;
  localparam int DPC_DW = 36;
  localparam int DPC_LANES = 4;
  localparam int DPC_PORTS = 2;
  localparam int DPC_PORT_L = 0;
  localparam int DPC_PORT_R = 1;
  // Mailbox words at the top of the array, one per port
  localparam logic [DPC_AW-1:0] DPC_MBOX_R = 18'h3ffff;
  localparam logic [DPC_AW-1:0] DPC_MBOX_L = 18'h3fffe;
  // Counter mask after reset: all bits count
  localparam logic [DPC_AW-1:0] DPC_MASK_RESET = 18'h3ffff;
  localparam logic [DPC_AW-1:0] DPC_CNT_RESET = 18'h00000;
  // Clock and port-to-port timing
  localparam real DPC_CLK_PERIOD_NS = 5.0;
  localparam real DPC_PORT_CLOCK_SKEW_MIN_NS = 8.0;
  // Reads after a colliding write until new data, skew not met
  localparam int DPC_COLLIDE_READS = 2;
  typedef enum logic [1:0] {DPC_OP_READ, DPC_OP_WRITE, DPC_OP_READBACK} dpc_op_t;
  typedef enum logic [1:0] {DPC_H_IDLE, DPC_H_ISSUE, DPC_H_WAIT, DPC_H_FLOAT} dpc_hstate_t;
endpackage : dpc_pkg

// File: common/dpc_if.sv
// Pin-level link between the dual-port RAM and its two port hosts
`timescale 1ns/10ps
interface dpc_if #(
  parameter int AW = dpc_pkg::DPC_AW,
  parameter int DW = dpc_pkg::DPC_DW
);
  logic master_clear_n;
  logic chip_select_low_active [2];
  logic chip_select_high_active [2];
  logic read_not_write [2];
  logic output_enable_n [2];
  logic [3:0] byte_lane_enables_n [2];
  logic address_strobe_n [2];
  logic counter_advance_n [2];
  logic counter_clear_n [2];
  logic counter_or_mask_select [2];
  logic [AW-1:0] addr_h [2];
  logic addr_h_oe [2];
  logic [AW-1:0] addr_d [2];
  logic addr_d_oe [2];
  logic [DW-1:0] data_h [2];
  logic data_h_oe [2];
  logic [DW-1:0] data_d [2];
  logic data_d_oe [2];
  logic counter_wrap_flag_n [2];
  logic mailbox_flag_n [2];
  modport device (
    input master_clear_n, chip_select_low_active, chip_select_high_active, read_not_write,
    input output_enable_n, byte_lane_enables_n, address_strobe_n, counter_advance_n,
    input counter_clear_n, counter_or_mask_select, addr_h, addr_h_oe, data_h, data_h_oe,
    output addr_d, addr_d_oe, data_d, data_d_oe, counter_wrap_flag_n, mailbox_flag_n
  );
  modport host (
    input master_clear_n, addr_d, addr_d_oe, data_d, data_d_oe, counter_wrap_flag_n,
    input mailbox_flag_n,
    output chip_select_low_active, chip_select_high_active, read_not_write, output_enable_n,
    output byte_lane_enables_n, address_strobe_n, counter_advance_n, counter_clear_n,
    output counter_or_mask_select, addr_h, addr_h_oe, data_h, data_h_oe
  );
endinterface : dpc_if

// File: rtl/dpc_device.sv
// Device end: both memory ports, burst counters, readback and mailbox flags
`timescale 1ns/10ps
module dpc_device #(
  parameter int AW = dpc_pkg::DPC_AW,
  parameter int DW = dpc_pkg::DPC_DW,
  parameter logic [dpc_pkg::DPC_AW-1:0] MBOX_R = dpc_pkg::DPC_MBOX_R,
  parameter logic [dpc_pkg::DPC_AW-1:0] MBOX_L = dpc_pkg::DPC_MBOX_L
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  dpc_if.device bus,
  input wire logic skew_met,
  output logic [1:0] port_selected
);
  import dpc_pkg::*;
  localparam int LW = DW / DPC_LANES;

  // Byte-lane merge of new data into an old word
  function automatic logic [DW-1:0] lane_merge(input logic [DW-1:0] old_w,
                                               input logic [DW-1:0] new_w,
                                               input logic [3:0] be_n);
    logic [DW-1:0] res;
    res = old_w;
    for (int i = 0; i < DPC_LANES; i++) begin
      if (!be_n[i]) begin
        res[i*LW +: LW] = new_w[i*LW +: LW];
      end
    end
    return res;
  endfunction : lane_merge

  logic [DW-1:0] mem [2**AW];
  logic [AW-1:0] cnt [2];
  logic [AW-1:0] base [2];
  logic [AW-1:0] mask [2];
  logic [AW-1:0] next_cnt [2];
  logic [AW-1:0] rb_val [2];
  logic rb_on [2];
  logic s1_v [2];
  logic [DW-1:0] s1_d [2];
  logic out_v [2];
  logic [DW-1:0] out_d [2];
  logic wrap_q [2];
  logic flag_q [2];
  logic sel [2];
  logic rd [2];
  logic wr [2];
  logic rb_cmd [2];
  logic adv [2];
  logic load [2];
  logic clr_all;
  logic [AW-1:0] mbox [2];

  // Master clear acts like reset on every piece of port state
  assign clr_all = rst || !bus.master_clear_n;
  assign mbox[DPC_PORT_L] = MBOX_L;
  assign mbox[DPC_PORT_R] = MBOX_R;

  for (genvar p = 0; p < DPC_PORTS; p++) begin : g_port
    localparam int Q = 1 - p;

    // Command decode from the sampled port pins
    always_comb begin
      sel[p] = !bus.chip_select_low_active[p] && bus.chip_select_high_active[p];
      rb_cmd[p] = !bus.address_strobe_n[p] && bus.counter_advance_n[p]
                  && bus.counter_clear_n[p];
      load[p] = !bus.address_strobe_n[p] && !bus.counter_advance_n[p]
                && bus.counter_or_mask_select[p];
      adv[p] = bus.address_strobe_n[p] && !bus.counter_advance_n[p];
      rd[p] = sel[p] && bus.read_not_write[p] && !rb_cmd[p];
      // Output still driving: the write is dropped, one turnaround cycle
      wr[p] = sel[p] && !bus.read_not_write[p] && !rb_cmd[p] && !bus.data_d_oe[p];
    end

    // Next address; the access uses it in this same cycle
    always_comb begin
      if (!bus.counter_clear_n[p]) begin
        next_cnt[p] = DPC_CNT_RESET;
      end else if (load[p]) begin
        next_cnt[p] = bus.addr_h[p];
      end else if (adv[p]) begin
        if ((cnt[p] & mask[p]) == mask[p]) begin
          next_cnt[p] = (cnt[p] & ~mask[p]) | (base[p] & mask[p]);
        end else begin
          next_cnt[p] = (cnt[p] & ~mask[p]) | ((cnt[p] + 1'b1) & mask[p]);
        end
      end else begin
        next_cnt[p] = cnt[p];
      end
    end

    // Counter, loaded base and mask
    always_ff @(posedge core_clk) begin
      if (clr_all) begin
        cnt[p] <= DPC_CNT_RESET;
        base[p] <= DPC_CNT_RESET;
        mask[p] <= DPC_MASK_RESET;
      end else if (clk_en) begin
        cnt[p] <= next_cnt[p];
        if (!bus.counter_clear_n[p]) begin
          base[p] <= DPC_CNT_RESET;
        end else if (load[p]) begin
          base[p] <= bus.addr_h[p];
        end
      end
    end

    // Wrap flag: low once the unmasked count reaches its top
    always_ff @(posedge core_clk) begin
      if (clr_all) begin
        wrap_q[p] <= 1'b0;
      end else if (clk_en) begin
        if (!bus.counter_clear_n[p] || load[p]) begin
          wrap_q[p] <= 1'b0;
        end else if (adv[p]) begin
          wrap_q[p] <= (next_cnt[p] & mask[p]) == mask[p];
        end
      end
    end
    assign bus.counter_wrap_flag_n[p] = !wrap_q[p];

    // Readback drives the address pins the cycle after the command
    always_ff @(posedge core_clk) begin
      if (clr_all) begin
        rb_on[p] <= 1'b0;
        rb_val[p] <= '0;
      end else if (clk_en) begin
        rb_on[p] <= rb_cmd[p];
        if (rb_cmd[p]) begin
          rb_val[p] <= bus.counter_or_mask_select[p] ? cnt[p] : mask[p];
        end
      end
    end
    assign bus.addr_d[p] = rb_val[p];
    assign bus.addr_d_oe[p] = rb_on[p];

    // Two-stage read pipe; a collision read sees new data only with skew met
    always_ff @(posedge core_clk) begin
      if (clr_all) begin
        s1_v[p] <= 1'b0;
        s1_d[p] <= '0;
        out_v[p] <= 1'b0;
        out_d[p] <= '0;
      end else if (clk_en) begin
        s1_v[p] <= rd[p];
        if (rd[p]) begin
          if (skew_met && wr[Q] && next_cnt[Q] == next_cnt[p]) begin
            s1_d[p] <= lane_merge(mem[next_cnt[p]], bus.data_h[Q],
                                  bus.byte_lane_enables_n[Q]);
          end else begin
            s1_d[p] <= mem[next_cnt[p]];
          end
        end
        out_v[p] <= s1_v[p];
        out_d[p] <= s1_d[p];
      end
    end
    // Output enable pin gates the drivers without a clock
    assign bus.data_d[p] = out_d[p];
    assign bus.data_d_oe[p] = out_v[p] && !bus.output_enable_n[p];

    // Own mailbox: set by the other port's write, cleared by own read
    always_ff @(posedge core_clk) begin
      if (clr_all) begin
        flag_q[p] <= 1'b0;
      end else if (clk_en) begin
        if (wr[Q] && next_cnt[Q] == mbox[p] && bus.byte_lane_enables_n[Q] != 4'hf) begin
          flag_q[p] <= 1'b1;
        end else if (rd[p] && next_cnt[p] == mbox[p]
                     && bus.byte_lane_enables_n[p] != 4'hf) begin
          flag_q[p] <= 1'b0;
        end
      end
    end
    assign bus.mailbox_flag_n[p] = !flag_q[p];
    assign port_selected[p] = sel[p];
  end

  // Array writes; both ports on one word is undefined, right wins here
  always_ff @(posedge core_clk) begin
    if (clk_en && !clr_all) begin
      for (int p = 0; p < DPC_PORTS; p++) begin
        if (wr[p]) begin
          mem[next_cnt[p]] <= lane_merge(mem[next_cnt[p]], bus.data_h[p],
                                         bus.byte_lane_enables_n[p]);
        end
      end
    end
  end
endmodule : dpc_device

// File: rtl/dpc_host.sv
// Host end: drives one memory port from simple user requests
`timescale 1ns/10ps
module dpc_host #(
  parameter int P = dpc_pkg::DPC_PORT_L,
  parameter int AW = dpc_pkg::DPC_AW,
  parameter int DW = dpc_pkg::DPC_DW
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  dpc_if.host bus,
  input wire logic req,
  input wire dpc_pkg::dpc_op_t req_op,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  input wire logic [3:0] req_be,
  input wire logic req_show_counter,
  output logic ready,
  output logic rsp_valid,
  output logic [DW-1:0] rsp_data,
  output logic [AW-1:0] rsp_addr,
  output logic counter_wrapped,
  output logic mailbox_pending
);
  import dpc_pkg::*;

  dpc_hstate_t state;
  dpc_op_t op_q;
  logic cs_on;
  logic strobe_n;
  logic advance_n;
  logic cm_sel;
  logic rw;
  logic oe_n;
  logic [3:0] be_n;
  logic [AW-1:0] addr_q;
  logic addr_oe;
  logic [DW-1:0] wdata_q;
  logic wdata_oe;

  assign ready = state == DPC_H_IDLE;
  assign counter_wrapped = !bus.counter_wrap_flag_n[P];
  assign mailbox_pending = !bus.mailbox_flag_n[P];

  // Pins come from flops, except counter clear, which is tied high
  assign bus.chip_select_low_active[P] = !cs_on;
  assign bus.chip_select_high_active[P] = cs_on;
  assign bus.read_not_write[P] = rw;
  assign bus.output_enable_n[P] = oe_n;
  assign bus.byte_lane_enables_n[P] = be_n;
  assign bus.address_strobe_n[P] = strobe_n;
  assign bus.counter_advance_n[P] = advance_n;
  assign bus.counter_clear_n[P] = 1'b1;
  assign bus.counter_or_mask_select[P] = cm_sel;
  assign bus.addr_h[P] = addr_q;
  assign bus.addr_h_oe[P] = addr_oe;
  assign bus.data_h[P] = wdata_q;
  assign bus.data_h_oe[P] = wdata_oe;

  // Request sequencer: one command cycle, then reads and readbacks wait for the answer; writes go straight back to idle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= DPC_H_IDLE;
      op_q <= DPC_OP_READ;
      cs_on <= 1'b0;
      strobe_n <= 1'b1;
      advance_n <= 1'b1;
      cm_sel <= 1'b1;
      rw <= 1'b1;
      oe_n <= 1'b1;
      be_n <= 4'hf;
      addr_q <= '0;
      addr_oe <= 1'b1;
      wdata_q <= '0;
      wdata_oe <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      rsp_addr <= '0;
    end else if (clk_en) begin
      rsp_valid <= 1'b0;
      unique case (state)
        DPC_H_IDLE: begin
          if (req) begin
            op_q <= req_op;
            cs_on <= req_op != DPC_OP_READBACK;
            // A read with the counter flag set advances the burst counter instead of loading
            strobe_n <= req_op == DPC_OP_READ && req_show_counter;
            advance_n <= req_op == DPC_OP_READBACK;
            cm_sel <= (req_op == DPC_OP_READBACK) ? req_show_counter : 1'b1;
            rw <= req_op != DPC_OP_WRITE;
            // Writes keep output enable high so no turnaround is lost
            oe_n <= req_op != DPC_OP_READ;
            be_n <= ~req_be;
            addr_q <= req_addr;
            // Let go of the address as the readback command goes out
            addr_oe <= req_op != DPC_OP_READBACK;
            wdata_q <= req_wdata;
            wdata_oe <= req_op == DPC_OP_WRITE;
            state <= DPC_H_ISSUE;
          end
        end
        DPC_H_ISSUE: begin
          cs_on <= 1'b0;
          strobe_n <= 1'b1;
          advance_n <= 1'b1;
          wdata_oe <= 1'b0;
          if (op_q == DPC_OP_WRITE) begin
            state <= DPC_H_IDLE;
          end else begin
            state <= DPC_H_WAIT;
          end
        end
        DPC_H_WAIT: begin
          // Readback value only stands in the cycle after the command edge
          if (op_q == DPC_OP_READBACK) begin
            if (bus.addr_d_oe[P]) begin
              rsp_addr <= bus.addr_d[P];
              rsp_valid <= 1'b1;
              state <= DPC_H_FLOAT;
            end
          end else if (bus.data_d_oe[P]) begin
            rsp_data <= bus.data_d[P];
            rsp_valid <= 1'b1;
            oe_n <= 1'b1;
            state <= DPC_H_IDLE;
          end
        end
        DPC_H_FLOAT: begin
          // Device address drivers are off from this cycle
          addr_oe <= 1'b1;
          state <= DPC_H_IDLE;
        end
      endcase
    end
  end
endmodule : dpc_host

// File: tb/dpc_check_sva.sv
// Pin-level checks on the link between the device and its two hosts
`timescale 1ns/10ps
module dpc_check (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic master_clear_n,
  input wire logic chip_select_low_active [2],
  input wire logic read_not_write [2],
  input wire logic output_enable_n [2],
  input wire logic [3:0] byte_lane_enables_n [2],
  input wire logic address_strobe_n [2],
  input wire logic counter_advance_n [2],
  input wire logic [dpc_pkg::DPC_AW-1:0] addr_h [2],
  input wire logic addr_h_oe [2],
  input wire logic addr_d_oe [2],
  input wire logic data_d_oe [2],
  input wire logic mailbox_flag_n [2]
);
  import dpc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst || !master_clear_n);
  // Selected access that loads the external address
  sequence s_acc(p, rnw);
    !chip_select_low_active[p] && read_not_write[p] == rnw
      && !address_strobe_n[p] && !counter_advance_n[p];
  endsequence
  // Readback command: strobe low, advance high
  sequence s_rback(p);
    !address_strobe_n[p] && counter_advance_n[p];
  endsequence
  a_readback_drive: assert property (s_rback(0) |=> addr_d_oe[0])
    else $error("readback not driven");
  a_host_release: assert property (addr_d_oe[0] |-> !addr_h_oe[0])
    else $error("address driven by both");
  a_host_redrive: assert property ($fell(addr_d_oe[0]) |-> !addr_h_oe[0])
    else $error("host redrove too early");
  a_left_read: assert property (s_acc(0, 1) ##0 !output_enable_n[0] |-> ##2 data_d_oe[0])
    else $error("left read data missing");
  a_right_read: assert property (s_acc(1, 1) ##0 !output_enable_n[1] |-> ##2 data_d_oe[1])
    else $error("right read data missing");
  // A lone read: data floats after the third edge
  a_read_float: assert property (s_acc(0, 1) ##1 chip_select_low_active[0] |-> ##2 !data_d_oe[0])
    else $error("read data did not float");
  a_mbox_set: assert property (s_acc(0, 0) ##0 (addr_h[0] == DPC_MBOX_R
      && byte_lane_enables_n[0] != 4'hf && !data_d_oe[0]) |=> !mailbox_flag_n[1])
    else $error("mailbox flag not set");
  a_mbox_lanes: assert property (s_acc(0, 0) ##0 (addr_h[0] == DPC_MBOX_R
      && byte_lane_enables_n[0] == 4'hf && mailbox_flag_n[1]) |=> mailbox_flag_n[1])
    else $error("flag set without lanes");
  a_mbox_clear: assert property (s_acc(1, 1) ##0 (addr_h[1] == DPC_MBOX_R
      && byte_lane_enables_n[1] != 4'hf && read_not_write[0]) |=> mailbox_flag_n[1])
    else $error("mailbox flag not cleared");
endmodule : dpc_check

// File: tb/dual_port_ram_counter_mailbox_tb_top.sv
// Testbench: two hosts facing the device across the pin interface
`timescale 1ns/10ps
module dual_port_ram_counter_mailbox_tb_top;
  import dpc_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic mclr_n = 1'b1;
  logic skew_met = 1'b0;
  logic req [2] = '{default: 1'b0};
  dpc_op_t req_op [2] = '{default: DPC_OP_READ};
  logic [DPC_AW-1:0] req_addr [2] = '{default: '0};
  logic [DPC_DW-1:0] req_wdata [2] = '{default: '0};
  logic [3:0] req_be [2] = '{default: '0};
  logic req_show [2] = '{default: 1'b0};
  logic ready [2];
  logic rsp_valid [2];
  logic [DPC_DW-1:0] rsp_data [2];
  logic [DPC_AW-1:0] rsp_addr [2];
  logic pend [2];
  logic wrapped [2];
  logic [DPC_DW-1:0] got_d [2];
  logic [DPC_AW-1:0] got_a [2];
  int bad_count = 0;
  int n_compared = 0;
  always #2.5 core_clk = ~core_clk;
  dpc_if dpc_if_i ();
  assign dpc_if_i.master_clear_n = mclr_n;
  dpc_device dpc_device_i (.core_clk, .rst, .clk_en(1'b1), .bus(dpc_if_i.device),
    .skew_met, .port_selected());
  // One host per port, index 0 left
  for (genvar p = 0; p < 2; p++) begin : g_host
    dpc_host #(.P(p)) dpc_host_i (.core_clk, .rst, .clk_en(1'b1), .bus(dpc_if_i.host),
      .req(req[p]), .req_op(req_op[p]), .req_addr(req_addr[p]), .req_wdata(req_wdata[p]),
      .req_be(req_be[p]), .req_show_counter(req_show[p]), .ready(ready[p]),
      .rsp_valid(rsp_valid[p]), .rsp_data(rsp_data[p]), .rsp_addr(rsp_addr[p]),
      .counter_wrapped(wrapped[p]), .mailbox_pending(pend[p]));
  end
  dpc_check dpc_check_i (.core_clk, .rst, .master_clear_n(dpc_if_i.master_clear_n),
    .chip_select_low_active(dpc_if_i.chip_select_low_active),
    .read_not_write(dpc_if_i.read_not_write), .output_enable_n(dpc_if_i.output_enable_n),
    .byte_lane_enables_n(dpc_if_i.byte_lane_enables_n),
    .address_strobe_n(dpc_if_i.address_strobe_n),
    .counter_advance_n(dpc_if_i.counter_advance_n), .addr_h(dpc_if_i.addr_h),
    .addr_h_oe(dpc_if_i.addr_h_oe), .addr_d_oe(dpc_if_i.addr_d_oe),
    .data_d_oe(dpc_if_i.data_d_oe), .mailbox_flag_n(dpc_if_i.mailbox_flag_n));
  task automatic chk_d(input logic [DPC_DW-1:0] got, input logic [DPC_DW-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t data %h exp %h", $time, got, exp);
    end
  endtask : chk_d
  task automatic chk_a(input logic [DPC_AW-1:0] got, input logic [DPC_AW-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t addr %h exp %h", $time, got, exp);
    end
  endtask : chk_a
  task automatic chk_b(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t flag %b exp %b", $time, got, exp);
    end
  endtask : chk_b
  // Held until an edge with ready high takes it; reads wait for the answer
  task automatic xfer(input int p, input dpc_op_t o, input logic [DPC_AW-1:0] a,
      input logic [DPC_DW-1:0] d, input logic [3:0] be, input logic sh);
    int n;
    n = 0;
    @(posedge core_clk);
    req[p] <= 1'b1;
    req_op[p] <= o;
    req_addr[p] <= a;
    req_wdata[p] <= d;
    req_be[p] <= be;
    req_show[p] <= sh;
    @(negedge core_clk);
    while (ready[p] !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
    req[p] <= 1'b0;
    while (o != DPC_OP_WRITE && rsp_valid[p] !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    got_d[p] = rsp_data[p];
    got_a[p] = rsp_addr[p];
    if (n >= 50) begin
      bad_count++;
      $display("CHECK FAILED %0t no answer", $time);
    end
  endtask : xfer
  // Lane merge across ports, then both readback sources
  task automatic t_access();
    xfer(0, DPC_OP_WRITE, 18'h00123, 36'h123456789, 4'hf, 1'b0);
    xfer(0, DPC_OP_WRITE, 18'h00123, 36'hfedcba987, 4'h5, 1'b0);
    xfer(1, DPC_OP_READ, 18'h00123, '0, 4'hf, 1'b0);
    chk_d(got_d[1], (36'hfedcba987 & 36'h007fc01ff) | (36'h123456789 & ~36'h007fc01ff));
    xfer(0, DPC_OP_READBACK, '0, '0, 4'hf, 1'b1);
    chk_a(got_a[0], 18'h00123);
    xfer(0, DPC_OP_READBACK, '0, '0, 4'hf, 1'b0);
    chk_a(got_a[0], DPC_MASK_RESET);
    $display("t_access done");
  endtask : t_access
  // Load below the top, advance onto it, then wrap back to the loaded word
  task automatic t_counter();
    xfer(0, DPC_OP_WRITE, 18'h3fffe, 36'h0000000a5, 4'hf, 1'b0);
    xfer(1, DPC_OP_WRITE, 18'h3ffff, 36'h00000005a, 4'hf, 1'b0);
    xfer(0, DPC_OP_READ, 18'h3fffe, '0, 4'hf, 1'b0);
    chk_d(got_d[0], 36'h0000000a5);
    chk_b(wrapped[0], 1'b0);
    xfer(0, DPC_OP_READ, '0, '0, 4'hf, 1'b1);
    chk_d(got_d[0], 36'h00000005a);
    chk_b(wrapped[0], 1'b1);
    xfer(0, DPC_OP_READ, '0, '0, 4'hf, 1'b1);
    chk_d(got_d[0], 36'h0000000a5);
    chk_b(wrapped[0], 1'b0);
    xfer(0, DPC_OP_READBACK, '0, '0, 4'hf, 1'b1);
    chk_a(got_a[0], 18'h3fffe);
    $display("t_counter done");
  endtask : t_counter
  // Same word written left, read right, in one cycle
  task automatic t_collide();
    @(posedge core_clk) skew_met <= 1'b1;
    xfer(0, DPC_OP_WRITE, 18'h01000, 36'h0aaaaaaaa, 4'hf, 1'b0);
    fork
      xfer(0, DPC_OP_WRITE, 18'h01000, 36'h155555555, 4'hf, 1'b0);
      xfer(1, DPC_OP_READ, 18'h01000, '0, 4'hf, 1'b0);
    join
    chk_d(got_d[1], 36'h155555555);
    @(posedge core_clk) skew_met <= 1'b0;
    fork
      xfer(0, DPC_OP_WRITE, 18'h01000, 36'h0f0f0f0f0, 4'hf, 1'b0);
      xfer(1, DPC_OP_READ, 18'h01000, '0, 4'hf, 1'b0);
    join
    chk_d(got_d[1], 36'h155555555);
    xfer(1, DPC_OP_READ, 18'h01000, '0, 4'hf, 1'b0);
    chk_d(got_d[1], 36'h0f0f0f0f0);
    $display("t_collide done");
  endtask : t_collide
  // Flags: no lanes, set, read clear, master clear
  task automatic t_mailbox();
    xfer(0, DPC_OP_WRITE, DPC_MBOX_R, 36'h000000001, 4'h0, 1'b0);
    repeat (2) @(negedge core_clk);
    chk_b(pend[1], 1'b0);
    xfer(0, DPC_OP_WRITE, DPC_MBOX_R, 36'h000000002, 4'h1, 1'b0);
    repeat (2) @(negedge core_clk);
    chk_b(pend[1], 1'b1);
    chk_b(pend[0], 1'b0);
    xfer(1, DPC_OP_READ, DPC_MBOX_R, '0, 4'hf, 1'b0);
    chk_b(pend[1], 1'b0);
    xfer(1, DPC_OP_WRITE, DPC_MBOX_L, 36'h000000003, 4'hf, 1'b0);
    repeat (2) @(negedge core_clk);
    chk_b(pend[0], 1'b1);
    @(posedge core_clk) mclr_n <= 1'b0;
    @(posedge core_clk) mclr_n <= 1'b1;
    @(negedge core_clk);
    chk_b(pend[0], 1'b0);
    $display("t_mailbox done");
  endtask : t_mailbox
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  // Main sequence after ten cycles of reset
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    t_access();
    t_counter();
    t_collide();
    t_mailbox();
    end_of_test();
  end
  // Tests need under two hundred cycles; this is over twenty times that
  initial begin
    repeat (4000) @(posedge core_clk);
    bad_count++;
    end_of_test();
  end
endmodule : dual_port_ram_counter_mailbox_tb_top
